// ===== hw/nvmac_regs.svh
// Offsets, field positions, reset values and timing counts of the
// non-volatile data memory controller.
// Assumes inclusion by bare name from the design files.
`ifndef NVMAC_REGS_SVH
`define NVMAC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NVMAC_ADDR_OFFSET 8'h00
`define NVMAC_DATA_OFFSET 8'h01
`define NVMAC_CTRL_OFFSET 8'h40
`define NVMAC_CTRL_BANK 8'h01
`define NVMAC_ADDR_BANK 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define NVMAC_FETCH_START_BIT 0
`define NVMAC_FETCH_ENABLE_BIT 1
`define NVMAC_PROGRAM_START_BIT 2
`define NVMAC_PROGRAM_ENABLE_BIT 3
`define NVMAC_ADDR_WIDTH 5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define NVMAC_RESET_BYTE 8'h00
`define NVMAC_BANK_RESET 8'h00
`define NVMAC_READ_CYCLES 2
`define NVMAC_TIMER_DIV 16
`define NVMAC_PROGRAM_TICKS 40

`endif

// ===== hw/nvmac_pkg.sv
// Types shared by the non-volatile data memory controller.
// Assumes the register header is compiled alongside.
package nvmac_pkg;

    // ----------------------------------------
    // Sequencer states, memory port and control register
    // ----------------------------------------
    typedef enum logic [1:0] {
        NVMAC_IDLE,
        NVMAC_FETCH,
        NVMAC_PROGRAM
    } nvmac_state_t;

    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } nvmac_mem_req_t;

    typedef struct packed {
        logic program_enable_bit;
        logic program_start;
        logic fetch_enable_bit;
        logic fetch_start;
    } nvmac_ctrl_t;

endpackage

// ===== hw/nvmac_store.sv
// Byte-wide storage array of the controller, 32 x 8 by default.
// Assumes a single clock; read data comes out of a register.
`timescale 1ns/10ps
module nvmac_store #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire nvmac_pkg::nvmac_mem_req_t req,
    output logic [7:0] rdata
);

    logic [7:0] mem [DEPTH];

    // Contents survive reset, as a non-volatile array would
    always_ff @(posedge core_clk) begin
        if (req_valid && req.wr) begin
            mem[req.addr] <= req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (req_valid && !req.wr) begin
            rdata <= mem[req.addr];
        end
    end

endmodule

// ===== hw/nvmac_timer.sv
// Free-running self-timed write timer, independent of software timing.
// Assumes start is a one-cycle pulse; done pulses once per cycle run.
`timescale 1ns/10ps
`include "nvmac_regs.svh"
module nvmac_timer #(
    parameter int DIV = `NVMAC_TIMER_DIV,
    parameter int TICKS = `NVMAC_PROGRAM_TICKS
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    output logic done
);

    logic [7:0] div_reg;
    logic [7:0] tick_reg;
    logic run_reg;
    wire tick = (div_reg == 8'(DIV - 1));

    // The divider never stops, so the write length depends on its phase
    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            run_reg <= 1'b0;
            tick_reg <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !run_reg) begin
                run_reg <= 1'b1;
                tick_reg <= 8'h00;
            end else if (run_reg && tick) begin
                if (tick_reg == 8'(TICKS - 1)) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    tick_reg <= tick_reg + 8'h01;
                end
            end
        end
    end

endmodule

// ===== hw/nvmac_top.sv
// Data memory access controller: address, data and control registers
// reached by the core, a byte store and a self-timed write sequencer.
// Assumes the core decodes its special function register bus into a
// bank number and an offset, and writes or reads one register a cycle.
//
// Summary of operation
// RL1 - Store holds 32 bytes, each access moves exactly one byte.
// RL2 - Address register keeps five bits, upper three read zero, reset zero.
// RL3 - Control register sits at offset 40H, bank 1, via indirect access.
// RL4 - Control bits: program enable 3, write start 2, fetch enable 1, start 0.
// RL5 - Write start launches a write only if program enable already set.
// RL6 - Write start clears itself when the byte has been stored.
// RL7 - Read start launches a read only if fetch enable already set.
// RL8 - Read end clears read start and loads the byte into data register.
// RL9 - Data register holds until a later read or write.
// RL10 - Reset clears program enable and the bank selector to zero.
// RL11 - Software sets one control bit per write, never both starts.
// RL12 - Software loads address and data, enables, then starts at once.
// RL13 - Software masks global interrupts around the write start.
// RL14 - Write length comes from an independent timer, variable in cycles.
// RL15 - Write end sets memory flag and the multi-function flag.
// RL16 - Vector request needs memory, multi-function and global enables.
// RL17 - Servicing clears only the multi-function flag; software clears other.
// RL18 - Software enables read, loads address, starts, polls till clear.
// RL19 - Busy cycle ignores new starts and keeps latched address and data.
`timescale 1ns/10ps
`include "nvmac_regs.svh"
module nvmac_top #(
    parameter int DEPTH = 32,
    parameter int AW = `NVMAC_ADDR_WIDTH
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] sfr_bank,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic [7:0] bank_select_pointer,
    input wire logic nvm_irq_enable,
    input wire logic mf_irq_enable,
    input wire logic global_irq_enable,
    input wire logic nvm_irq_flag_clr,
    input wire logic mf_irq_ack,
    output logic nvm_irq_flag,
    output logic mf_irq_flag,
    output logic irq_request,
    output logic busy
);

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    function automatic logic sel(input logic [7:0] bank,
                                 input logic [7:0] addr,
                                 input logic [7:0] want_bank,
                                 input logic [7:0] want_addr);
        sel = (bank == want_bank) && (addr == want_addr);
    endfunction

    // Bank pointer is modelled here as an SFR at offset 04H, decoded in every bank
    localparam logic [7:0] BANK_PTR_OFFSET = 8'h04;

    wire hit_addr = sel(sfr_bank, sfr_addr, `NVMAC_ADDR_BANK,
                        `NVMAC_ADDR_OFFSET);
    wire hit_data = sel(sfr_bank, sfr_addr, `NVMAC_ADDR_BANK,
                        `NVMAC_DATA_OFFSET);
    // Control register is reachable only through bank 1 at 40H
    wire hit_ctrl = sel(sfr_bank, sfr_addr, `NVMAC_CTRL_BANK,
                        `NVMAC_CTRL_OFFSET); // RL3
    wire hit_bank = (sfr_addr == BANK_PTR_OFFSET);

    // ----------------------------------------
    // Registers and sequencer state
    // ----------------------------------------
    logic [AW-1:0] nvm_address_register;
    logic [7:0] nvm_data_register;
    nvmac_pkg::nvmac_ctrl_t ctrl_reg;
    nvmac_pkg::nvmac_ctrl_t ctrl_next;
    nvmac_pkg::nvmac_state_t state_reg;
    nvmac_pkg::nvmac_state_t state_next;
    nvmac_pkg::nvmac_mem_req_t lat_reg;
    logic [1:0] fetch_cnt_reg;
    logic [7:0] store_rdata;
    logic prog_done;

    wire idle = (state_reg == nvmac_pkg::NVMAC_IDLE);
    wire ctrl_wr = sfr_wr && hit_ctrl;
    wire [7:0] ctrl_wbits = sfr_wdata;

    // Starts are honoured only with the matching enable already stored
    wire launch_prog = idle && ctrl_wr &&
                       ctrl_wbits[`NVMAC_PROGRAM_START_BIT] &&
                       !ctrl_reg.program_start &&
                       ctrl_reg.program_enable_bit; // RL5
    wire launch_fetch = idle && ctrl_wr &&
                        ctrl_wbits[`NVMAC_FETCH_START_BIT] &&
                        !ctrl_reg.fetch_start &&
                        ctrl_reg.fetch_enable_bit &&
                        !launch_prog; // RL7
    wire fetch_end = (state_reg == nvmac_pkg::NVMAC_FETCH) &&
                     (fetch_cnt_reg == 2'(`NVMAC_READ_CYCLES - 1));
    wire prog_end = (state_reg == nvmac_pkg::NVMAC_PROGRAM) && prog_done;

    // ----------------------------------------
    // Control register next value
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next.program_enable_bit =
                ctrl_wbits[`NVMAC_PROGRAM_ENABLE_BIT];
            ctrl_next.fetch_enable_bit = ctrl_wbits[`NVMAC_FETCH_ENABLE_BIT];
            // Software may not abort a running cycle by writing zero
            if (idle) begin
                ctrl_next.program_start = launch_prog; // RL5
                ctrl_next.fetch_start = launch_fetch; // RL7
            end
        end
        if (fetch_end) begin
            ctrl_next.fetch_start = 1'b0; // RL8
        end
        if (prog_end) begin
            ctrl_next.program_start = 1'b0; // RL6
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            nvmac_pkg::NVMAC_IDLE: begin
                if (launch_prog) begin
                    state_next = nvmac_pkg::NVMAC_PROGRAM;
                end else if (launch_fetch) begin
                    state_next = nvmac_pkg::NVMAC_FETCH;
                end
            end
            nvmac_pkg::NVMAC_FETCH: begin
                if (fetch_end) begin
                    state_next = nvmac_pkg::NVMAC_IDLE;
                end
            end
            nvmac_pkg::NVMAC_PROGRAM: begin
                if (prog_done) begin
                    state_next = nvmac_pkg::NVMAC_IDLE; // RL14
                end
            end
            default: begin
                state_next = nvmac_pkg::NVMAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= nvmac_pkg::NVMAC_IDLE;
            ctrl_reg <= '0; // RL4 RL10
            fetch_cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            fetch_cnt_reg <= (state_reg == nvmac_pkg::NVMAC_FETCH) ?
                             fetch_cnt_reg + 2'h1 : 2'h0;
        end
    end

    // Address and data are latched at launch and frozen while busy
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lat_reg <= '0;
        end else if (launch_prog || launch_fetch) begin
            lat_reg.wr <= launch_prog;
            lat_reg.addr <= nvm_address_register; // RL19
            lat_reg.wdata <= nvm_data_register; // RL19
        end
    end

    // ----------------------------------------
    // Address, data and bank registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            nvm_address_register <= '0; // RL2
            bank_select_pointer <= `NVMAC_BANK_RESET; // RL10
        end else begin
            if (sfr_wr && hit_addr) begin
                nvm_address_register <= sfr_wdata[AW-1:0]; // RL2
            end
            if (sfr_wr && hit_bank) begin
                bank_select_pointer <= sfr_wdata;
            end
        end
    end

    // Read result wins over a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            nvm_data_register <= `NVMAC_RESET_BYTE;
        end else if (fetch_end) begin
            nvm_data_register <= store_rdata; // RL8
        end else if (sfr_wr && hit_data) begin
            nvm_data_register <= sfr_wdata; // RL9
        end
    end

    // ----------------------------------------
    // Store and write timer
    // ----------------------------------------
    // Read is issued on the first FETCH cycle, data ready on the second
    wire mem_fire = ((state_reg == nvmac_pkg::NVMAC_FETCH) &&
                     (fetch_cnt_reg == 2'h0)) || prog_end;

    nvmac_store #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .core_clk(core_clk),
        .srst(srst),
        .req_valid(mem_fire), // RL1
        .req(lat_reg),
        .rdata(store_rdata)
    );

    nvmac_timer u_timer (
        .core_clk(core_clk),
        .srst(srst),
        .start(launch_prog), // RL14
        .done(prog_done)
    );

    // ----------------------------------------
    // Interrupt flags
    // ----------------------------------------
    // Set beats clear so that a completion is never lost
    always_ff @(posedge core_clk) begin
        if (srst) begin
            nvm_irq_flag <= 1'b0;
            mf_irq_flag <= 1'b0;
        end else begin
            nvm_irq_flag <= prog_end | (nvm_irq_flag &
                            !nvm_irq_flag_clr); // RL15 RL17
            mf_irq_flag <= prog_end | (mf_irq_flag & !mf_irq_ack); // RL15 RL17
        end
    end

    assign irq_request = nvm_irq_flag && mf_irq_flag && nvm_irq_enable &&
                         mf_irq_enable && global_irq_enable; // RL16
    assign busy = !idle;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [7:0] addr_rd = {{(8 - AW){1'b0}}, nvm_address_register}; // RL2
    wire [7:0] ctrl_rd = {4'h0, ctrl_reg}; // RL4

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= hit_addr ? addr_rd :
                         hit_data ? nvm_data_register :
                         hit_ctrl ? ctrl_rd :
                         hit_bank ? bank_select_pointer : 8'h00;
        end
    end

endmodule

// ===== testbench/nvmac_chk.sv
// Port-level timing checker for the data memory access controller.
// Assumes it is bound to nvmac_top and sees only that module's ports.
`timescale 1ns/10ps
module nvmac_chk (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] sfr_bank,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] bank_select_pointer,
    input wire logic nvm_irq_enable,
    input wire logic mf_irq_enable,
    input wire logic global_irq_enable,
    input wire logic nvm_irq_flag_clr,
    input wire logic mf_irq_ack,
    input wire logic nvm_irq_flag,
    input wire logic mf_irq_flag,
    input wire logic irq_request,
    input wire logic busy
);
    // ----------------------------------------
    // Shadow of the enable bits
    // ----------------------------------------
    logic fetch_en_reg;
    logic prog_en_reg;
    logic prog_run_reg;
    wire ctrl_hit = sfr_wr && sfr_bank == 8'h01 && sfr_addr == 8'h40;
    wire rd_addr = sfr_rd && sfr_bank == 8'h00 && sfr_addr == 8'h00;
    wire rd_ctrl = sfr_rd && sfr_bank == 8'h01 && sfr_addr == 8'h40;
    wire prog_go = ctrl_hit && sfr_wdata[2] && prog_en_reg && !busy;
    wire fetch_go = ctrl_hit && sfr_wdata[0] && !sfr_wdata[2]
        && fetch_en_reg && !busy;
    // Enables follow every control write, even while a cycle runs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fetch_en_reg <= 1'b0;
            prog_en_reg <= 1'b0;
            prog_run_reg <= 1'b0;
        end else begin
            fetch_en_reg <= ctrl_hit ? sfr_wdata[1] : fetch_en_reg;
            prog_en_reg <= ctrl_hit ? sfr_wdata[3] : prog_en_reg;
            prog_run_reg <= prog_go ? 1'b1 : (busy ? prog_run_reg : 1'b0);
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence fetch_cycle_s;
        busy [*2] ##1 !busy;
    endsequence
    sequence prog_cycle_s;
        busy [*8] ##[610:640] !busy;
    endsequence
    read_cycle_a: assert property (fetch_go |=> fetch_cycle_s)
        else $error("read cycle length wrong");
    write_cycle_a: assert property (prog_go |=> prog_cycle_s)
        else $error("write cycle length wrong");
    write_refuse_a: assert property (ctrl_hit && sfr_wdata[2]
        && !sfr_wdata[0] && !prog_en_reg && !busy |=> !busy)
        else $error("write started without enable");
    read_refuse_a: assert property (ctrl_hit && sfr_wdata[0]
        && !sfr_wdata[2] && !fetch_en_reg && !busy |=> !busy)
        else $error("read started without enable");
    flags_set_a: assert property (prog_run_reg && !busy
        |-> ##[0:2] (nvm_irq_flag && mf_irq_flag))
        else $error("write end did not raise both flags");
    nvm_hold_a: assert property (nvm_irq_flag && !nvm_irq_flag_clr
        |=> nvm_irq_flag)
        else $error("memory flag cleared without software");
    // A write can only end while busy, so no set competes here
    mf_clear_a: assert property (mf_irq_ack && !busy
        |=> !mf_irq_flag)
        else $error("service did not clear multi-function flag");
    irq_gate_a: assert property (irq_request == (nvm_irq_flag
        && mf_irq_flag && nvm_irq_enable && mf_irq_enable
        && global_irq_enable))
        else $error("interrupt request gating wrong");
    addr_upper_a: assert property (rd_addr |=> sfr_rdata[7:5] == 3'h0)
        else $error("address upper bits not zero");
    ctrl_upper_a: assert property (rd_ctrl |=> sfr_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    reset_clear_a: assert property ($fell(srst)
        |-> bank_select_pointer == 8'h00 && !busy && !nvm_irq_flag)
        else $error("outputs not cleared by reset");
endmodule

bind nvmac_top nvmac_chk u_chk (.core_clk, .srst, .sfr_bank, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .bank_select_pointer,
    .nvm_irq_enable, .mf_irq_enable, .global_irq_enable,
    .nvm_irq_flag_clr, .mf_irq_ack, .nvm_irq_flag, .mf_irq_flag,
    .irq_request, .busy);

// ===== testbench/data_eeprom_access_control_test.sv
// Self-checking bench for the data memory access controller.
// Assumes the design and checker files are compiled before this one.
`timescale 1ns/10ps
module data_eeprom_access_control_test;
    logic core_clk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_bank = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic nvm_irq_enable = 1'b1, mf_irq_enable = 1'b1;
    logic global_irq_enable = 1'b1, nvm_irq_flag_clr = 1'b0;
    logic mf_irq_ack = 1'b0, note = 1'b0, pend = 1'b0;
    logic [7:0] sfr_rdata, bank_select_pointer, got, exp, a[2], d[2];
    logic nvm_irq_flag, mf_irq_flag, irq_request, busy;
    logic [7:0] notes[$];
    int mismatches = 0, n_compared = 0;
    nvmac_top DUT (.core_clk, .srst, .sfr_bank, .sfr_addr, .sfr_wr,
        .sfr_rd, .sfr_wdata, .sfr_rdata, .bank_select_pointer,
        .nvm_irq_enable, .mf_irq_enable, .global_irq_enable,
        .nvm_irq_flag_clr, .mf_irq_ack, .nvm_irq_flag, .mf_irq_flag,
        .irq_request, .busy);
    always #4 core_clk = ~core_clk;
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One access, then an idle cycle so strobes never retoggle at once
    task automatic acc(input logic w, input logic [7:0] b, ad, dt);
        sfr_wr = w;
        sfr_rd = !w;
        sfr_bank = b;
        sfr_addr = ad;
        sfr_wdata = dt;
        @(posedge core_clk);
        #1;
        got = sfr_rdata;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] b, ad, dt);
        acc(1'b1, b, ad, dt);
    endtask
    task automatic rd_chk(input logic [7:0] b, ad, e);
        notes.push_back(e);
        note = 1'b1;
        acc(1'b0, b, ad, 8'h00);
        note = 1'b0;
    endtask
    // Bounded poll of the control register until the masked bit drops
    task automatic poll(input logic [7:0] m);
        int n;
        n = 0;
        got = m;
        while ((got & m) !== 8'h00 && n < 500) begin
            acc(1'b0, 8'h01, 8'h40, 8'h00);
            n++;
        end
        if (n >= 500) mismatches++;
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk) pend <= sfr_rd && note;
    always @(negedge core_clk) begin
        if (pend) begin
            exp = notes.pop_front();
            check(sfr_rdata, exp);
        end
    end
    initial begin
        #80000;
        mismatches++;
        stop_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(79426));
        repeat (4) @(posedge core_clk);
        #1;
        srst = 1'b0;
        rd_chk(8'h00, 8'h00, 8'h00);
        rd_chk(8'h00, 8'h01, 8'h00);
        rd_chk(8'h01, 8'h40, 8'h00);
        rd_chk(8'h00, 8'h04, 8'h00);
        wr(8'h00, 8'h04, 8'h01);
        rd_chk(8'h01, 8'h04, 8'h01);
        wr(8'h01, 8'h04, 8'h00);
        wr(8'h00, 8'h00, 8'hff);
        rd_chk(8'h00, 8'h00, 8'h1f);
        $display("test reset and address mask done");
        wr(8'h00, 8'h40, 8'h02);
        rd_chk(8'h01, 8'h40, 8'h00);
        wr(8'h01, 8'h40, 8'h04);
        rd_chk(8'h01, 8'h40, 8'h00);
        wr(8'h01, 8'h40, 8'h01);
        rd_chk(8'h01, 8'h40, 8'h00);
        $display("test refused starts done");
        for (int i = 0; i < 2; i++) begin
            a[i] = i ? 8'h1f : 8'h00;
            d[i] = 8'($urandom);
            wr(8'h00, 8'h00, a[i]);
            wr(8'h00, 8'h01, d[i]);
            global_irq_enable = 1'b0;
            wr(8'h01, 8'h40, 8'h08);
            wr(8'h01, 8'h40, 8'h0c);
            global_irq_enable = 1'b1;
            // Busy cycle must keep its latched address and data
            wr(8'h00, 8'h00, 8'h05);
            wr(8'h00, 8'h01, ~d[i]);
            wr(8'h01, 8'h40, 8'h0b);
            poll(8'h04);
            rd_chk(8'h01, 8'h40, 8'h0a);
            check({5'h00, nvm_irq_flag, mf_irq_flag, irq_request}, 8'h07);
            global_irq_enable = 1'b0;
            #1;
            check({7'h00, irq_request}, 8'h00);
            global_irq_enable = 1'b1;
            mf_irq_ack = 1'b1;
            @(posedge core_clk);
            #1;
            mf_irq_ack = 1'b0;
            check({6'h00, nvm_irq_flag, mf_irq_flag}, 8'h02);
            nvm_irq_flag_clr = 1'b1;
            @(posedge core_clk);
            #1;
            nvm_irq_flag_clr = 1'b0;
            check({7'h00, nvm_irq_flag}, 8'h00);
        end
        $display("test write cycles done");
        wr(8'h01, 8'h40, 8'h02);
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, 8'h00, a[i]);
            wr(8'h00, 8'h01, 8'h5a);
            wr(8'h01, 8'h40, 8'h03);
            wr(8'h00, 8'h00, a[i] ^ 8'h1f);
            poll(8'h01);
            rd_chk(8'h00, 8'h01, d[i]);
            rd_chk(8'h00, 8'h01, d[i]);
        end
        $display("test read back done");
        stop_test();
    end
endmodule
